// ### rtl/hdu_pkg.sv
// Package with shared constants for the nine-bit half-duplex serial block
`default_nettype none
package hdu_pkg;
	localparam logic [7:0] SERIAL_DATA_PORT_ADDR      = 8'hd6;
	localparam logic [7:0] SERIAL_CONTROL_STATUS_ADDR = 8'hd7;
	localparam int RECEIVE_FULL_BIT   = 7;
	localparam int TRANSMIT_DONE_BIT  = 6;
	localparam int RECEIVE_IRQ_EN_BIT = 5;
	localparam int TRANSMIT_IRQ_BIT   = 4;
	localparam int BAUD_LSB           = 1;
	localparam int NINTH_BIT          = 0;
	localparam logic [2:0] BAUD_RESET = 3'h0;
	localparam int OVERSAMPLE         = 8;
	localparam int CHAR_BITS          = 11;
	localparam int DATA_BITS          = 9;
	// Sample phases inside one bit for the majority vote
	localparam logic [2:0] SAMPLE_A   = 3'h3;
	localparam logic [2:0] SAMPLE_B   = 3'h4;
	localparam logic [2:0] SAMPLE_C   = 3'h5;
	// Internal clock division per baud code (oversample tick = division / 8)
	localparam int DIV_0 = 6656;
	localparam int DIV_1 = 3328;
	localparam int DIV_2 = 1664;
	localparam int DIV_3 = 832;
	localparam int DIV_4 = 416;
	localparam int DIV_5 = 256;
	localparam int DIV_6 = 208;
	localparam int TICK_W = 10;
endpackage : hdu_pkg
`default_nettype wire

// ### rtl/hdu_link_if.sv
// Interface carrying the serial line pair between the two ends
`default_nettype none
interface hdu_link_if;
	logic dev_txd;
	logic dev_txd_oe;
	logic far_txd;
	logic far_txd_oe;
	// Idle line is high when nobody drives
	logic dev_rxd;
	logic far_rxd;
	assign dev_rxd = far_txd_oe ? far_txd : 1'b1;
	assign far_rxd = dev_txd_oe ? dev_txd : 1'b1;
	modport device (output dev_txd, output dev_txd_oe, input dev_rxd);
	modport remote (output far_txd, output far_txd_oe, input far_rxd);
endinterface : hdu_link_if
`default_nettype wire

// ### rtl/hdu_tick_gen.sv
// Oversample tick generator: one pulse every division/8 clocks
`default_nettype none
module hdu_tick_gen
	import hdu_pkg::*;
(
	input  wire logic       i_clk_sys,
	input  wire logic       i_arst_n,
	input  wire logic       i_sync_clr,
	input  wire logic [2:0] i_baud_select,
	output logic            o_tick
);
	logic [TICK_W-1:0] cnt_ff;
	logic [TICK_W-1:0] nxt_cnt;
	logic [TICK_W-1:0] limit;
	logic              tick_ff;
	logic              nxt_tick;

	// Terminal count from the baud code; reserved code runs at the slowest rate
	always_comb begin
		case (i_baud_select)
			3'h0: limit = TICK_W'(DIV_0 / OVERSAMPLE - 1);
			3'h1: limit = TICK_W'(DIV_1 / OVERSAMPLE - 1);
			3'h2: limit = TICK_W'(DIV_2 / OVERSAMPLE - 1);
			3'h3: limit = TICK_W'(DIV_3 / OVERSAMPLE - 1);
			3'h4: limit = TICK_W'(DIV_4 / OVERSAMPLE - 1);
			3'h5: limit = TICK_W'(DIV_5 / OVERSAMPLE - 1);
			3'h6: limit = TICK_W'(DIV_6 / OVERSAMPLE - 1);
			default: limit = TICK_W'(DIV_0 / OVERSAMPLE - 1);
		endcase
	end

	// Counter; new code takes effect at once through the compare
	always_comb begin
		nxt_tick = 1'b0;
		if (i_sync_clr) begin
			nxt_cnt = '0;
		end else if (cnt_ff >= limit) begin
			nxt_cnt  = '0;
			nxt_tick = 1'b1;
		end else begin
			nxt_cnt = cnt_ff + 1'b1;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			cnt_ff  <= '0;
			tick_ff <= 1'b0;
		end else begin
			cnt_ff  <= nxt_cnt;
			tick_ff <= nxt_tick;
		end
	end

	assign o_tick = tick_ff;
endmodule : hdu_tick_gen
`default_nettype wire

// ### rtl/hdu_device.sv
// Device end: nine-bit half-duplex serial transceiver with two byte registers
// Functional notes
// R1: Flag and enable both set request interrupt
// R2: Data write loads shifter, starts sending
// R3: Data write clears transmit-done flag
// R4: Data read returns receive buffer
// R5: Software avoids read-modify-write on data
// R6: Baud code selects clock division
// R7: Baud change acts at once
// R8: Receive-full set when buffer loaded
// R9: Software writes set or clear receive-full
// R10: Transmit-done set after stop bit
// R11: Writing zero clears transmit-done
// R12: Receive irq enable leaves flag alone
// R13: Transmit irq enable leaves flag alone
// R14: Control bit 0 sets ninth sent bit
// R15: Control bit 0 reads received ninth bit
// R16: Parity computed by software
// R17: Start, eight data lsb first, ninth, stop
// R18: Eight-times oversample, two-of-three vote
// R19: Falling edge, skip start, nine bits, stop
// R20: Transmit aborts reception, has priority
// R21: Reset clears flags, enables, baud, activity
`default_nettype none
module hdu_device
	import hdu_pkg::*;
(
	input  wire logic       i_clk_sys,
	input  wire logic       i_arst_n,
	input  wire logic [7:0] i_addr,
	input  wire logic [7:0] i_wdata,
	input  wire logic       i_wr,
	input  wire logic       i_rd,
	output logic      [7:0] o_rdata,
	output logic            o_tx_irq,
	output logic            o_rx_irq,
	output logic            o_serial_output_enable,
	hdu_link_if.device      link
);
	typedef enum logic [1:0] {ST_IDLE, ST_TX, ST_RX} hdu_state_t;

	hdu_state_t  state_ff, nxt_state;
	logic [2:0]  phase_ff, nxt_phase;
	logic [3:0]  bitn_ff, nxt_bitn;
	logic [10:0] sh_ff, nxt_sh;
	logic [8:0]  rxsh_ff, nxt_rxsh;
	logic [1:0]  votes_ff, nxt_votes;
	logic [7:0]  rxbuf_ff, nxt_rxbuf;
	logic        rx_full_ff, nxt_rx_full;
	logic        tx_done_ff, nxt_tx_done;
	logic        rx_ie_ff, nxt_rx_ie;
	logic        tx_ie_ff, nxt_tx_ie;
	logic [2:0]  baud_ff, nxt_baud;
	logic        ninth_ff, nxt_ninth;
	logic        txd_ff, nxt_txd;
	logic        oe_ff, nxt_oe;
	logic [7:0]  rdata_ff, nxt_rdata;
	logic        txirq_ff, rxirq_ff;
	logic        rx_s1_ff, rx_s2_ff, rx_prev_ff;
	logic        tick, tick_clr, wr_data, wr_ctrl, rx_done;

	// Two-flop synchroniser and edge history for the line input
	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			rx_s1_ff   <= 1'b1;
			rx_s2_ff   <= 1'b1;
			rx_prev_ff <= 1'b1;
		end else begin
			rx_s1_ff   <= link.dev_rxd;
			rx_s2_ff   <= rx_s1_ff;
			rx_prev_ff <= rx_s2_ff;
		end
	end

	assign wr_data = i_wr && (i_addr == SERIAL_DATA_PORT_ADDR);
	assign wr_ctrl = i_wr && (i_addr == SERIAL_CONTROL_STATUS_ADDR);

	hdu_tick_gen u_tick (
		.i_clk_sys     (i_clk_sys),
		.i_arst_n      (i_arst_n),
		.i_sync_clr    (tick_clr),
		.i_baud_select (baud_ff), // R6 R7
		.o_tick        (tick)
	);

	// Character sequencer: transmit, receive and the idle watch
	always_comb begin
		nxt_state = state_ff;
		nxt_phase = phase_ff;
		nxt_bitn  = bitn_ff;
		nxt_sh    = sh_ff;
		nxt_rxsh  = rxsh_ff;
		nxt_votes = votes_ff;
		nxt_txd   = txd_ff;
		nxt_oe    = oe_ff;
		tick_clr  = 1'b0;
		rx_done   = 1'b0;
		if (wr_data) begin
			// Stop bit, ninth bit, data lsb first, start bit
			nxt_sh    = {1'b1, ninth_ff, i_wdata, 1'b0}; // R2 R14 R17
			nxt_state = ST_TX; // R20
			nxt_phase = '0;
			nxt_bitn  = '0;
			nxt_oe    = 1'b1;
			nxt_txd   = 1'b0;
			tick_clr  = 1'b1;
		end else begin
			case (state_ff)
				ST_IDLE: begin
					if (rx_prev_ff && !rx_s2_ff) begin
						nxt_state = ST_RX; // R19
						nxt_phase = '0;
						nxt_bitn  = '0;
						nxt_votes = '0;
						tick_clr  = 1'b1;
					end
				end
				ST_TX: begin
					if (tick) begin
						nxt_phase = phase_ff + 3'h1;
						if (phase_ff == 3'h7) begin
							if (bitn_ff == 4'(CHAR_BITS - 1)) begin
								nxt_state = ST_IDLE;
								nxt_oe    = 1'b0;
								nxt_txd   = 1'b1;
							end else begin
								nxt_bitn = bitn_ff + 4'h1;
								nxt_sh   = {1'b1, sh_ff[10:1]};
								nxt_txd  = sh_ff[1];
							end
						end
					end
				end
				ST_RX: begin
					if (tick) begin
						nxt_phase = phase_ff + 3'h1;
						if ((phase_ff == SAMPLE_A || phase_ff == SAMPLE_B ||
						     phase_ff == SAMPLE_C) && rx_s2_ff) begin
							nxt_votes = votes_ff + 2'h1; // R18
						end
						if (phase_ff == 3'h7) begin
							nxt_votes = '0;
							nxt_bitn  = bitn_ff + 4'h1;
							if (bitn_ff != '0 && bitn_ff <= 4'(DATA_BITS)) begin
								// Majority of three, lsb first into the shifter
								nxt_rxsh = {(votes_ff >= 2'h2 || (votes_ff == 2'h1 &&
								             phase_ff == SAMPLE_C && rx_s2_ff)) ? 1'b1 :
								             (votes_ff == 2'h2), rxsh_ff[8:1]};
							end
							if (bitn_ff == 4'(CHAR_BITS - 1)) begin
								nxt_state = ST_IDLE;
								rx_done   = 1'b1; // R19
							end
						end
					end
				end
				default: begin
					nxt_state = ST_IDLE;
				end
			endcase
		end
	end

	// Register file; hardware set wins over software clear, except that a data write clears transmit-done
	always_comb begin
		nxt_rx_full = rx_full_ff;
		nxt_tx_done = tx_done_ff;
		nxt_rx_ie   = rx_ie_ff;
		nxt_tx_ie   = tx_ie_ff;
		nxt_baud    = baud_ff;
		nxt_ninth   = ninth_ff;
		nxt_rxbuf   = rxbuf_ff;
		if (wr_ctrl) begin
			nxt_rx_full = i_wdata[RECEIVE_FULL_BIT]; // R9
			nxt_tx_done = tx_done_ff & i_wdata[TRANSMIT_DONE_BIT]; // R11
			nxt_rx_ie   = i_wdata[RECEIVE_IRQ_EN_BIT]; // R12
			nxt_tx_ie   = i_wdata[TRANSMIT_IRQ_BIT]; // R13
			nxt_baud    = i_wdata[BAUD_LSB +: 3]; // R6 R7
			nxt_ninth   = i_wdata[NINTH_BIT]; // R14
		end
		if (wr_data) begin
			nxt_tx_done = 1'b0; // R3
		end
		if (state_ff == ST_TX && tick && phase_ff == 3'h7 &&
		    bitn_ff == 4'(CHAR_BITS - 1) && !wr_data) begin
			nxt_tx_done = 1'b1; // R10
		end
		if (rx_done) begin
			nxt_rxbuf   = rxsh_ff[7:0] ;
			nxt_ninth   = rxsh_ff[8]; // R15
			nxt_rx_full = 1'b1; // R8
		end
	end

	// Read mux: data port shows the receive buffer only
	always_comb begin
		nxt_rdata = 8'h00;
		if (i_rd && i_addr == SERIAL_DATA_PORT_ADDR) begin
			nxt_rdata = rxbuf_ff; // R4
		end else if (i_rd && i_addr == SERIAL_CONTROL_STATUS_ADDR) begin
			nxt_rdata = {rx_full_ff, tx_done_ff, rx_ie_ff, tx_ie_ff, baud_ff, ninth_ff};
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			state_ff   <= ST_IDLE; // R21
			phase_ff   <= '0;
			bitn_ff    <= '0;
			sh_ff      <= '1;
			rxsh_ff    <= '0;
			votes_ff   <= '0;
			rxbuf_ff   <= '0;
			rx_full_ff <= 1'b0;
			tx_done_ff <= 1'b0;
			rx_ie_ff   <= 1'b0;
			tx_ie_ff   <= 1'b0;
			baud_ff    <= BAUD_RESET;
			ninth_ff   <= 1'b0;
			txd_ff     <= 1'b1;
			oe_ff      <= 1'b0;
			rdata_ff   <= '0;
			txirq_ff   <= 1'b0;
			rxirq_ff   <= 1'b0;
		end else begin
			state_ff   <= nxt_state;
			phase_ff   <= nxt_phase;
			bitn_ff    <= nxt_bitn;
			sh_ff      <= nxt_sh;
			rxsh_ff    <= nxt_rxsh;
			votes_ff   <= nxt_votes;
			rxbuf_ff   <= nxt_rxbuf;
			rx_full_ff <= nxt_rx_full;
			tx_done_ff <= nxt_tx_done;
			rx_ie_ff   <= nxt_rx_ie;
			tx_ie_ff   <= nxt_tx_ie;
			baud_ff    <= nxt_baud;
			ninth_ff   <= nxt_ninth;
			txd_ff     <= nxt_txd;
			oe_ff      <= nxt_oe;
			rdata_ff   <= nxt_rdata;
			txirq_ff   <= nxt_tx_done & nxt_tx_ie; // R1
			rxirq_ff   <= nxt_rx_full & nxt_rx_ie; // R1 R9
		end
	end

	assign o_rdata                = rdata_ff;
	assign o_tx_irq               = txirq_ff;
	assign o_rx_irq               = rxirq_ff;
	assign o_serial_output_enable = oe_ff;
	assign link.dev_txd           = txd_ff;
	assign link.dev_txd_oe        = oe_ff;
endmodule : hdu_device
`default_nettype wire

// ### rtl/hdu_remote.sv
// Remote end: simple nine-bit transceiver driven by a user strobe
`default_nettype none
module hdu_remote
	import hdu_pkg::*;
(
	input  wire logic       i_clk_sys,
	input  wire logic       i_arst_n,
	input  wire logic [2:0] i_baud_select,
	input  wire logic [8:0] i_tx_data,
	input  wire logic       i_tx_start,
	output logic            o_tx_busy,
	output logic      [8:0] o_rx_data,
	output logic            o_rx_valid,
	hdu_link_if.remote      link
);
	logic [10:0] sh_ff, nxt_sh;
	logic [3:0]  tbit_ff, nxt_tbit;
	logic [2:0]  tph_ff, nxt_tph;
	logic        busy_ff, nxt_busy;
	logic [8:0]  rsh_ff, nxt_rsh;
	logic [3:0]  rbit_ff, nxt_rbit;
	logic [2:0]  rph_ff, nxt_rph;
	logic        rbusy_ff, nxt_rbusy;
	logic [8:0]  rdat_ff, nxt_rdat;
	logic        rval_ff, nxt_rval;
	logic        s1_ff, s2_ff, prev_ff;
	logic        tick;

	hdu_tick_gen u_tick (
		.i_clk_sys     (i_clk_sys),
		.i_arst_n      (i_arst_n),
		.i_sync_clr    (1'b0),
		.i_baud_select (i_baud_select),
		.o_tick        (tick)
	);

	// Line synchroniser
	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			s1_ff   <= 1'b1;
			s2_ff   <= 1'b1;
			prev_ff <= 1'b1;
		end else begin
			s1_ff   <= link.far_rxd;
			s2_ff   <= s1_ff;
			prev_ff <= s2_ff;
		end
	end

	// Transmit and receive sequencing, single mid-bit sample
	always_comb begin
		nxt_sh = sh_ff;
		nxt_tbit = tbit_ff;
		nxt_tph = tph_ff;
		nxt_busy = busy_ff;
		nxt_rsh = rsh_ff;
		nxt_rbit = rbit_ff;
		nxt_rph = rph_ff;
		nxt_rbusy = rbusy_ff;
		nxt_rdat = rdat_ff;
		nxt_rval = 1'b0;
		if (!busy_ff && i_tx_start) begin
			nxt_sh = {1'b1, i_tx_data, 1'b0};
			nxt_busy = 1'b1;
			nxt_tbit = '0;
			nxt_tph = '0;
		end else if (busy_ff && tick) begin
			nxt_tph = tph_ff + 3'h1;
			if (tph_ff == 3'h7) begin
				nxt_sh = {1'b1, sh_ff[10:1]};
				nxt_tbit = tbit_ff + 4'h1;
				nxt_busy = (tbit_ff != 4'(CHAR_BITS - 1));
			end
		end
		if (!rbusy_ff && prev_ff && !s2_ff) begin
			nxt_rbusy = 1'b1;
			nxt_rbit = '0;
			nxt_rph = '0;
		end else if (rbusy_ff && tick) begin
			nxt_rph = rph_ff + 3'h1;
			if (rph_ff == SAMPLE_B) begin
				if (rbit_ff != '0 && rbit_ff <= 4'(DATA_BITS)) begin
					nxt_rsh = {s2_ff, rsh_ff[8:1]};
				end
			end
			if (rph_ff == 3'h7) begin
				nxt_rbit = rbit_ff + 4'h1;
				if (rbit_ff == 4'(CHAR_BITS - 1)) begin
					nxt_rbusy = 1'b0;
					nxt_rdat = rsh_ff;
					nxt_rval = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			sh_ff <= '1;
			tbit_ff <= '0;
			tph_ff <= '0;
			busy_ff <= 1'b0;
			rsh_ff <= '0;
			rbit_ff <= '0;
			rph_ff <= '0;
			rbusy_ff <= 1'b0;
			rdat_ff <= '0;
			rval_ff <= 1'b0;
		end else begin
			sh_ff <= nxt_sh;
			tbit_ff <= nxt_tbit;
			tph_ff <= nxt_tph;
			busy_ff <= nxt_busy;
			rsh_ff <= nxt_rsh;
			rbit_ff <= nxt_rbit;
			rph_ff <= nxt_rph;
			rbusy_ff <= nxt_rbusy;
			rdat_ff <= nxt_rdat;
			rval_ff <= nxt_rval;
		end
	end

	assign o_tx_busy = busy_ff;
	assign o_rx_data = rdat_ff;
	assign o_rx_valid = rval_ff;
	assign link.far_txd = sh_ff[0];
	assign link.far_txd_oe = busy_ff;
endmodule : hdu_remote
`default_nettype wire

// ### verif/hdu_link_monitor.sv
// Checker for the serial line pair between device and remote ends
`default_nettype none
module hdu_link_monitor (
	input wire logic i_clk_sys,
	input wire logic i_arst_n,
	input wire logic dev_txd,
	input wire logic dev_txd_oe,
	input wire logic far_txd,
	input wire logic far_txd_oe,
	input wire logic dev_rxd,
	input wire logic far_rxd
);
	int   run_ff;
	int   len_ff;
	logic txd_ff;
	int   nxt_run;
	int   nxt_len;
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_arst_n);
	// Cycles since last level change and since frame start
	always_comb begin
		nxt_run = (dev_txd != txd_ff) ? 0 : run_ff + 1;
		nxt_len = dev_txd_oe ? len_ff + 1 : 0;
	end
	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			run_ff <= 0;
			len_ff <= 0;
			txd_ff <= 1'b1;
		end else begin
			run_ff <= nxt_run;
			len_ff <= nxt_len;
			txd_ff <= dev_txd;
		end
	end
	a_start_low: assert property ($rose(dev_txd_oe) |-> !dev_txd [*8])
		else $error("start bit not low");
	a_stop_high: assert property ($fell(dev_txd_oe) |-> $past(dev_txd) && $past(dev_txd, 8))
		else $error("stop bit not high");
	a_frame_len: assert property ($fell(dev_txd_oe) |-> len_ff >= 2288)
		else $error("frame too short");
	a_bit_spacing: assert property (dev_txd_oe && $past(dev_txd_oe) && dev_txd != txd_ff
		|-> run_ff >= 207)
		else $error("bit shorter than fastest rate");
	a_idle_high: assert property (!dev_txd_oe |-> dev_txd && far_rxd)
		else $error("idle line not high");
	a_wire_follows: assert property (dev_txd_oe |-> far_rxd == dev_txd)
		else $error("line does not carry device output");
	a_far_start: assert property ($rose(far_txd_oe) |-> !dev_rxd [*8])
		else $error("remote start bit not low");
	a_far_stop: assert property ($fell(far_txd_oe) |-> $past(far_txd) && $past(far_txd, 8))
		else $error("remote stop bit not high");
endmodule // hdu_link_monitor
`default_nettype wire

// ### verif/tb_half_duplex_nine_bit_uart.sv
// Self-checking bench for device and remote ends joined by the link
`default_nettype none
module tb_half_duplex_nine_bit_uart;
	timeunit 1ns;
	timeprecision 1ps;
	import hdu_pkg::*;
	localparam logic [7:0] CR = SERIAL_CONTROL_STATUS_ADDR;
	localparam logic [7:0] DR = SERIAL_DATA_PORT_ADDR;
	logic       clk    = 1'b0;
	logic       rst_n  = 1'b0;
	logic [7:0] addr   = 8'h00;
	logic [7:0] wdata  = 8'h00;
	logic       wr     = 1'b0;
	logic       rd     = 1'b0;
	logic [2:0] rbaud  = 3'h6;
	logic [8:0] rdat   = 9'h000;
	logic       rstart = 1'b0;
	logic [7:0] rdata;
	logic       tx_irq;
	logic       rx_irq;
	logic       oe;
	logic       rbusy;
	logic [8:0] rrx;
	logic       rvalid;
	int         num_errors = 0;
	int         checks     = 0;
	hdu_link_if link ();
	// Free-running system clock
	always #4 clk = ~clk;
	hdu_device i_hdu_device (.i_clk_sys(clk), .i_arst_n(rst_n), .i_addr(addr), .i_wdata(wdata),
		.i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_tx_irq(tx_irq), .o_rx_irq(rx_irq),
		.o_serial_output_enable(oe), .link(link.device));
	hdu_remote i_hdu_remote (.i_clk_sys(clk), .i_arst_n(rst_n), .i_baud_select(rbaud),
		.i_tx_data(rdat), .i_tx_start(rstart), .o_tx_busy(rbusy), .o_rx_data(rrx),
		.o_rx_valid(rvalid), .link(link.remote));
	hdu_link_monitor i_hdu_link_monitor (.i_clk_sys(clk), .i_arst_n(rst_n),
		.dev_txd(link.dev_txd), .dev_txd_oe(link.dev_txd_oe), .far_txd(link.far_txd),
		.far_txd_oe(link.far_txd_oe), .dev_rxd(link.dev_rxd), .far_rxd(link.far_rxd));
	// Bus cycles, compare and bounded wait
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk(rdata & m, e);
	endtask
	task automatic wait_hi(ref logic s, input int lim);
		int n;
		n = 0;
		while (s !== 1'b1 && n < lim) begin
			@(posedge clk);
			n++;
		end
		#1 chk(s, 1'b1);
	endtask
	task automatic t_reset();
		rc(CR, 8'hff, 8'h00);
		chk({tx_irq, rx_irq, oe}, 3'h0);
		$display("reset test done");
	endtask
	task automatic t_tx(input logic [8:0] v);
		logic [10:0] exp;
		int i;
		exp = {1'b1, v, 1'b0};
		wr_reg(CR, {4'h5, 3'h6, v[8]});
		wr_reg(DR, v[7:0]);
		wait_hi(oe, 4);
		rc(CR, 8'hfe, 8'h1c);
		repeat (100) @(posedge clk);
		for (i = 0; i < 11; i++) begin
			chk(link.far_rxd, exp[i]);
			repeat (208) @(posedge clk);
		end
		chk(rrx, v);
		rc(CR, 8'hfe, 8'h5c);
		chk(tx_irq, 1'b1);
		$display("transmit test done");
	endtask
	task automatic t_flags();
		wr_reg(CR, 8'h4c);
		rc(CR, 8'hfe, 8'h4c);
		chk(tx_irq, 1'b0);
		wr_reg(CR, 8'h0c);
		rc(CR, 8'hfe, 8'h0c);
		$display("flag test done");
	endtask
	task automatic t_rx();
		wr_reg(CR, 8'h2c);
		@(posedge clk);
		rdat <= 9'h13c;
		rstart <= 1'b1;
		@(posedge clk);
		rstart <= 1'b0;
		#1 chk(rbusy, 1'b1);
		wait_hi(rx_irq, 3000);
		rc(CR, 8'hff, 8'had);
		rc(DR, 8'hff, 8'h3c);
		wr_reg(CR, 8'h2c);
		rc(CR, 8'hff, 8'h2c);
		chk(rx_irq, 1'b0);
		wr_reg(CR, 8'hac);
		rc(CR, 8'hff, 8'hac);
		chk(rx_irq, 1'b1);
		wr_reg(CR, 8'h8c);
		rc(CR, 8'hff, 8'h8c);
		chk(rx_irq, 1'b0);
		wr_reg(CR, 8'h0c);
		$display("receive test done");
	endtask
	task automatic t_abort();
		@(posedge clk);
		rdat <= 9'h0ff;
		rstart <= 1'b1;
		@(posedge clk);
		rstart <= 1'b0;
		repeat (600) @(posedge clk);
		t_tx(9'h0c3);
		$display("abort test done");
	endtask
	task automatic t_baud();
		int dv[4] = '{DIV_3, DIV_4, DIV_5, DIV_6};
		int k;
		int n;
		for (k = 0; k < 4; k++) begin
			wr_reg(CR, {4'h4, 3'(k + 3), 1'b0});
			wr_reg(DR, 8'h00);
			wait_hi(oe, 4);
			n = 0;
			while (oe === 1'b1 && n < 20000) begin
				@(posedge clk);
				n++;
			end
			chk(16'(n + dv[k] / 8 >= 11 * dv[k] && n <= 11 * dv[k] + dv[k] / 8), 16'h1);
		end
		$display("baud test done");
	endtask
	task automatic wrap_up();
		$display("checks %0d errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// Main sequence
	initial begin
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		t_reset();
		t_tx(9'h1a5);
		t_tx(9'h05a);
		t_flags();
		t_rx();
		t_abort();
		t_baud();
		wrap_up();
	end
	// Watchdog against a hang
	initial begin
		repeat (60000) @(posedge clk);
		num_errors++;
		wrap_up();
	end
endmodule // tb_half_duplex_nine_bit_uart
`default_nettype wire
